// *** bclr_mem_model.sv ***
// System memory model holding one bulk descriptor list.
// Assumes the walker fetches from the current pointer while serving.
`timescale 1ns/10ps
`default_nettype none
module bclr_mem_model
  import bclr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serve_i,
  input wire logic [BCLR_DATA_W-1:0] cur_i,
  input wire logic [3:0] dly_i,
  output bclr_advance_t adv_o
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
      adv_o <= '0;
    end else if (serve_i && !adv_o.valid && cnt_r >= dly_i) begin
      cnt_r <= 4'h0;
      adv_o.valid <= 1'b1;
      // Links in insertion order, last one ends the list
      adv_o.next_addr <= (cur_i == 32'h0000_0120) ? 32'h0000_0000 : cur_i + 32'h0000_0010;
    end else begin
      cnt_r <= serve_i ? cnt_r + 4'h1 : 4'h0;
      adv_o.valid <= 1'b0;
      // Released link data keeps changing so a stale capture shows up
      adv_o.next_addr <= ~adv_o.next_addr;
    end
  end
endmodule
`default_nettype wire

// *** bclr_pkg.sv ***
// Constants and carrier types shared by the bulk list pointer block.
// Assumes a single core clock domain and a word-wide register port.
package bclr_pkg;

  localparam int unsigned BCLR_DATA_W = 32;
  localparam int unsigned BCLR_ADDR_W = 8;
  localparam int unsigned BCLR_PTR_LSB = 4;
  localparam int unsigned BCLR_PTR_W = BCLR_DATA_W - BCLR_PTR_LSB;

  // Register offsets within the controller register space
  localparam logic [BCLR_ADDR_W-1:0] BCLR_OFS_BULK_HEAD = 8'h28;
  localparam logic [BCLR_ADDR_W-1:0] BCLR_OFS_BULK_CURRENT = 8'h2C;

  // Reset values and the low nibble that reserved bits read as
  localparam logic [BCLR_PTR_W-1:0] BCLR_PTR_RESET = 28'h000_0000;
  localparam logic [BCLR_PTR_LSB-1:0] BCLR_RSVD_VAL = 4'h0;
  localparam logic [BCLR_DATA_W-1:0] BCLR_RDATA_NONE = 32'h0000_0000;

  // Pointer value that marks the end of the bulk list
  localparam logic [BCLR_PTR_W-1:0] BCLR_PTR_END = 28'h000_0000;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [BCLR_ADDR_W-1:0] addr;
    logic [BCLR_DATA_W-1:0] wdata;
  } bclr_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [BCLR_DATA_W-1:0] next_addr;
  } bclr_advance_t;

  typedef enum logic [1:0] {
    BCLR_IDLE,
    BCLR_ACTIVE,
    BCLR_END_CHECK
  } bclr_state_t;

endpackage

// *** bclr_ptr_reg.sv ***
// One 16-byte aligned descriptor pointer register with a single load port.
// Assumes the caller resolves load priority before driving load_i.
`timescale 1ns/10ps
`default_nettype none
module bclr_ptr_reg
  import bclr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [BCLR_PTR_W-1:0] load_val_i,
  output logic [BCLR_PTR_W-1:0] q_o
);

  logic [BCLR_PTR_W-1:0] ptr_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_r <= BCLR_PTR_RESET;
    end else if (load_i) begin
      ptr_r <= load_val_i;
    end
  end

  assign q_o = ptr_r;

endmodule
`default_nettype wire

// *** bclr_top.sv ***
// Bulk list head and current descriptor pointers with the list walker.
// Assumes the descriptor fetch engine, the shared area loader, the command
// status flag and the control enable all run on CORE_CLK_I.
`timescale 1ns/10ps
`default_nettype none

module bclr_top
  import bclr_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire bclr_reg_req_t REG_REQ_I,
  output logic [BCLR_DATA_W-1:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic INIT_LOAD_I,
  input wire logic [BCLR_DATA_W-1:0] INIT_HEAD_ADDR_I,
  input wire logic BULK_LIST_ENABLE_I,
  input wire logic LIST_FILLED_I,
  output logic LIST_FILLED_CLR_O,
  input wire logic FRAME_BULK_START_I,
  input wire logic FRAME_BULK_STOP_I,
  input wire bclr_advance_t ADVANCE_I,
  output logic [BCLR_DATA_W-1:0] BULK_HEAD_ADDR_O,
  output logic [BCLR_DATA_W-1:0] BULK_CURRENT_ADDR_O,
  output logic BULK_SERVE_O,
  output logic BULK_LIST_END_O
);

  // Full byte address from a stored pointer, low nibble forced to zero
  function automatic logic [BCLR_DATA_W-1:0] ptr_to_addr(input logic [BCLR_PTR_W-1:0] p);
    ptr_to_addr = {p, BCLR_RSVD_VAL};
  endfunction

  // Pointer field of a full address; the low nibble is dropped on purpose
  function automatic logic [BCLR_PTR_W-1:0] addr_to_ptr(input logic [BCLR_DATA_W-1:0] a);
    addr_to_ptr = a[BCLR_DATA_W-1:BCLR_PTR_LSB];
  endfunction

  logic [BCLR_PTR_W-1:0] head_q;
  logic [BCLR_PTR_W-1:0] cur_q;
  logic head_load;
  logic [BCLR_PTR_W-1:0] head_nxt;
  logic cur_load;
  logic [BCLR_PTR_W-1:0] cur_nxt;
  logic sw_head_wr;
  logic sw_cur_wr;
  logic sw_head_rd;
  logic sw_cur_rd;
  logic walk_advance;
  logic walk_refill;
  logic [BCLR_PTR_W-1:0] adv_ptr;

  bclr_state_t state_r;
  bclr_state_t state_nxt;
  logic clr_pulse_r;
  logic clr_pulse_nxt;
  logic [BCLR_DATA_W-1:0] rdata_r;
  logic rvalid_r;
  logic [BCLR_DATA_W-1:0] head_addr_r;
  logic [BCLR_DATA_W-1:0] cur_addr_r;

  // Register port decode
  always_comb begin
    sw_head_wr = 1'b0;
    sw_cur_wr = 1'b0;
    sw_head_rd = 1'b0;
    sw_cur_rd = 1'b0;
    if (REG_REQ_I.addr == BCLR_OFS_BULK_HEAD) begin
      sw_head_wr = REG_REQ_I.wr_en;
      sw_head_rd = REG_REQ_I.rd_en;
    end else if (REG_REQ_I.addr == BCLR_OFS_BULK_CURRENT) begin
      // A write while the list runs would race the walker, so it is dropped
      sw_cur_wr = REG_REQ_I.wr_en && !BULK_LIST_ENABLE_I;
      sw_cur_rd = REG_REQ_I.rd_en;
    end
  end

  assign adv_ptr = addr_to_ptr(ADVANCE_I.next_addr);

  // Walker: resume, advance along the links, check the flag at the end
  always_comb begin
    state_nxt = state_r;
    clr_pulse_nxt = 1'b0;
    walk_advance = 1'b0;
    walk_refill = 1'b0;
    case (state_r)
      BCLR_IDLE: begin
        if (FRAME_BULK_START_I && BULK_LIST_ENABLE_I) begin
          if (cur_q != BCLR_PTR_END) begin
            state_nxt = BCLR_ACTIVE;
          end else begin
            state_nxt = BCLR_END_CHECK;
          end
        end
      end
      BCLR_ACTIVE: begin
        if (FRAME_BULK_STOP_I || !BULK_LIST_ENABLE_I) begin
          state_nxt = BCLR_IDLE;
        end else if (ADVANCE_I.valid) begin
          walk_advance = 1'b1;
          if (adv_ptr == BCLR_PTR_END) begin
            state_nxt = BCLR_END_CHECK;
          end
        end
      end
      BCLR_END_CHECK: begin
        if (FRAME_BULK_STOP_I || !BULK_LIST_ENABLE_I) begin
          state_nxt = BCLR_IDLE;
        end else if (LIST_FILLED_I) begin
          walk_refill = 1'b1;
          clr_pulse_nxt = 1'b1;
          if (head_q != BCLR_PTR_END) begin
            state_nxt = BCLR_ACTIVE;
          end else begin
            state_nxt = BCLR_IDLE;
          end
        end else begin
          state_nxt = BCLR_IDLE;
        end
      end
      default: begin
        state_nxt = BCLR_IDLE;
      end
    endcase
  end

  // Head pointer sources; initialization wins over a software write
  always_comb begin
    head_load = 1'b0;
    head_nxt = head_q;
    if (INIT_LOAD_I) begin
      head_load = 1'b1;
      head_nxt = addr_to_ptr(INIT_HEAD_ADDR_I);
    end else if (sw_head_wr) begin
      head_load = 1'b1;
      head_nxt = addr_to_ptr(REG_REQ_I.wdata);
    end
  end

  // Current pointer sources; the walker owns it while the list is enabled
  always_comb begin
    cur_load = 1'b0;
    cur_nxt = cur_q;
    if (walk_refill) begin
      cur_load = 1'b1;
      cur_nxt = head_q;
    end else if (walk_advance) begin
      cur_load = 1'b1;
      cur_nxt = adv_ptr;
    end else if (sw_cur_wr) begin
      cur_load = 1'b1;
      cur_nxt = addr_to_ptr(REG_REQ_I.wdata);
    end
  end

  bclr_ptr_reg u_head (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .load_i(head_load),
    .load_val_i(head_nxt),
    .q_o(head_q)
  );

  // Reset value zero marks an empty list until software or the walker fills it
  bclr_ptr_reg u_current (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .load_i(cur_load),
    .load_val_i(cur_nxt),
    .q_o(cur_q)
  );

  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_r <= BCLR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      clr_pulse_r <= 1'b0;
    end else begin
      clr_pulse_r <= clr_pulse_nxt;
    end
  end

  // Reads return the live pointer, so a read while enabled sees the walk
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdata_r <= BCLR_RDATA_NONE;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= REG_REQ_I.rd_en;
      if (sw_head_rd) begin
        rdata_r <= ptr_to_addr(head_q);
      end else if (sw_cur_rd) begin
        rdata_r <= ptr_to_addr(cur_q);
      end else if (REG_REQ_I.rd_en) begin
        rdata_r <= BCLR_RDATA_NONE;
      end
    end
  end

  // Address outputs are registered from the next pointer values, so they match the pointers with no lag
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      head_addr_r <= BCLR_RDATA_NONE;
      cur_addr_r <= BCLR_RDATA_NONE;
    end else begin
      head_addr_r <= ptr_to_addr(head_nxt);
      cur_addr_r <= ptr_to_addr(cur_nxt);
    end
  end

  assign REG_RDATA_O = rdata_r;
  assign REG_RVALID_O = rvalid_r;
  assign LIST_FILLED_CLR_O = clr_pulse_r;
  assign BULK_HEAD_ADDR_O = head_addr_r;
  assign BULK_CURRENT_ADDR_O = cur_addr_r;
  assign BULK_SERVE_O = (state_r == BCLR_ACTIVE);
  assign BULK_LIST_END_O = (state_r == BCLR_END_CHECK);

endmodule
`default_nettype wire

// *** bclr_top_sva.sv ***
// Checker for the bulk list pointer block.
// Sees only the top ports; bound at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module bclr_top_sva
  import bclr_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire bclr_reg_req_t REG_REQ_I,
  input wire logic [BCLR_DATA_W-1:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire logic INIT_LOAD_I,
  input wire logic [BCLR_DATA_W-1:0] INIT_HEAD_ADDR_I,
  input wire logic BULK_LIST_ENABLE_I,
  input wire logic LIST_FILLED_I,
  input wire logic LIST_FILLED_CLR_O,
  input wire logic FRAME_BULK_START_I,
  input wire logic FRAME_BULK_STOP_I,
  input wire bclr_advance_t ADVANCE_I,
  input wire logic [BCLR_DATA_W-1:0] BULK_HEAD_ADDR_O,
  input wire logic [BCLR_DATA_W-1:0] BULK_CURRENT_ADDR_O,
  input wire logic BULK_SERVE_O,
  input wire logic BULK_LIST_END_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  wire logic go = BULK_LIST_ENABLE_I && !FRAME_BULK_STOP_I;
  wire logic [31:0] cur = BULK_CURRENT_ADDR_O;
  wire logic [31:0] ih = {INIT_HEAD_ADDR_I[31:4], 4'h0};
  wire logic [31:0] an = {ADVANCE_I.next_addr[31:4], 4'h0};
  sequence s_end_full;
    BULK_LIST_END_O && LIST_FILLED_I && go;
  endsequence
  sequence s_refilled;
    LIST_FILLED_CLR_O && cur == BULK_HEAD_ADDR_O;
  endsequence
  property p_rv;
    REG_REQ_I.rd_en |=> REG_RVALID_O && REG_RDATA_O[3:0] == 4'h0;
  endproperty
  property p_al;
    cur[3:0] == 4'h0 && BULK_HEAD_ADDR_O[3:0] == 4'h0;
  endproperty
  property p_init;
    INIT_LOAD_I |=> BULK_HEAD_ADDR_O == $past(ih);
  endproperty
  property p_fill;
    s_end_full |=> s_refilled;
  endproperty
  property p_none;
    BULK_LIST_END_O && !LIST_FILLED_I && go |=> !LIST_FILLED_CLR_O && !BULK_SERVE_O && $stable(cur);
  endproperty
  property p_adv;
    BULK_SERVE_O && ADVANCE_I.valid && go |=> cur == $past(an);
  endproperty
  property p_last;
    BULK_SERVE_O && ADVANCE_I.valid && go && an == 32'h0000_0000 |=> BULK_LIST_END_O;
  endproperty
  property p_go;
    !BULK_SERVE_O && !BULK_LIST_END_O && FRAME_BULK_START_I && go && cur != 32'h0000_0000
      |=> BULK_SERVE_O;
  endproperty
  // While enabled and idle nothing may move the current pointer, software included
  property p_lock;
    BULK_LIST_ENABLE_I && !BULK_SERVE_O && !BULK_LIST_END_O |=> $stable(cur);
  endproperty
  a_rv: assert property (p_rv) else $error("read answer wrong");
  a_al: assert property (p_al) else $error("pointer low nibble set");
  a_init: assert property (p_init) else $error("init head load wrong");
  a_fill: assert property (p_fill) else $error("refill wrong");
  a_none: assert property (p_none) else $error("empty flag acted on");
  a_adv: assert property (p_adv) else $error("advance wrong");
  a_last: assert property (p_last) else $error("list end missed");
  a_go: assert property (p_go) else $error("resume missed");
  a_lock: assert property (p_lock) else $error("current written while on");
endmodule
bind bclr_top bclr_top_sva u_sva (.CORE_CLK_I, .RESET_I, .REG_REQ_I, .REG_RDATA_O,
  .REG_RVALID_O, .INIT_LOAD_I, .INIT_HEAD_ADDR_I, .BULK_LIST_ENABLE_I, .LIST_FILLED_I,
  .LIST_FILLED_CLR_O, .FRAME_BULK_START_I, .FRAME_BULK_STOP_I, .ADVANCE_I,
  .BULK_HEAD_ADDR_O, .BULK_CURRENT_ADDR_O, .BULK_SERVE_O, .BULK_LIST_END_O);
`default_nettype wire

// *** bclr_top_tb.sv ***
// Testbench for the bulk list pointer block.
// Assumes the memory model and the checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module bclr_top_tb
  import bclr_pkg::*;
;
  logic clk = 0, rst = 1, init = 0, en = 0, lf = 0, st = 0, sp = 0;
  bclr_reg_req_t req = '0;
  logic [31:0] ih = 32'h0000_0207;
  logic [3:0] dly = 4'h4;
  bclr_advance_t adv;
  logic [31:0] rdata, head, cur;
  logic rv, clr, serve, lend;
  int error_cnt = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  bclr_top uut (.CORE_CLK_I(clk), .RESET_I(rst), .REG_REQ_I(req), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rv), .INIT_LOAD_I(init), .INIT_HEAD_ADDR_I(ih), .BULK_LIST_ENABLE_I(en),
    .LIST_FILLED_I(lf), .LIST_FILLED_CLR_O(clr), .FRAME_BULK_START_I(st),
    .FRAME_BULK_STOP_I(sp), .ADVANCE_I(adv), .BULK_HEAD_ADDR_O(head),
    .BULK_CURRENT_ADDR_O(cur), .BULK_SERVE_O(serve), .BULK_LIST_END_O(lend));
  bclr_mem_model mem (.clk_i(clk), .rst_i(rst), .serve_i(serve), .cur_i(cur), .dly_i(dly),
    .adv_o(adv));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 32'h0000_0000};
    @(negedge clk);
    req = '0;
    chk("rvalid", 32'h0000_0001, {31'h0, rv});
    chk("rdata", e, rdata);
  endtask
  // Waits under a bound for list end, flag clear or an advance
  // A wait that runs out is counted as a mismatch, so a stalled walk cannot pass
  task automatic wait_hi(input int k);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 200 && !hit; i++) begin
      hit = ((k == 0 ? lend : k == 1 ? clr : adv.valid) === 1'b1);
      if (!hit) begin
        @(negedge clk);
      end
    end
    chk("wait", 32'h0000_0001, {31'h0, hit});
  endtask
  task automatic start;
    @(negedge clk);
    st = 1;
    @(negedge clk);
    st = 0;
  endtask
  task report_and_stop;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 0;
    rd(BCLR_OFS_BULK_HEAD, 32'h0000_0000);
    rd(BCLR_OFS_BULK_CURRENT, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    init = 1;
    @(negedge clk);
    init = 0;
    rd(BCLR_OFS_BULK_HEAD, 32'h0000_0200);
    wr(BCLR_OFS_BULK_HEAD, 32'h0000_0100);
    rd(BCLR_OFS_BULK_HEAD, 32'h0000_0100);
    chk("head out", 32'h0000_0100, head);
    wr(BCLR_OFS_BULK_CURRENT, 32'h0000_0110);
    rd(BCLR_OFS_BULK_CURRENT, 32'h0000_0110);
    en = 1;
    rd(BCLR_OFS_BULK_CURRENT, 32'h0000_0110);
    start;
    wait_hi(2);
    @(negedge clk);
    sp = 1;
    @(negedge clk);
    sp = 0;
    chk("serve", 32'h0000_0000, {31'h0, serve});
    rd(BCLR_OFS_BULK_CURRENT, 32'h0000_0120);
    start;
    wait_hi(0);
    @(negedge clk);
    chk("current", 32'h0000_0000, cur);
    lf = 1;
    start;
    wait_hi(1);
    lf = 0;
    chk("refill", 32'h0000_0100, cur);
    for (int j = 1; j <= 3; j++) begin
      wait_hi(2);
      @(negedge clk);
      chk("walk", j == 3 ? 32'h0000_0000 : 32'h0000_0100 + 32'(j) * 32'h0000_0010, cur);
    end
    chk("end", 32'h0000_0001, {31'h0, lend});
    report_and_stop;
  end
endmodule
`default_nettype wire
